// ===== logic/arb_pkg.sv
// shared constants and types for the three-wire bus arbiter
package arb_pkg;
	// synchroniser depth: request and acknowledge are usable within two clocks
	localparam int SYNC_STAGES = 2;
	// number of asynchronous inputs brought through the synchroniser
	localparam int ASYNC_INPUTS = 2;
	// bit positions in the synchroniser vector
	localparam int SYNC_BIT_REQ = 0;
	localparam int SYNC_BIT_ACK = 1;
	// reset values
	localparam logic GRANT_RESET = 1'b0;
	localparam logic FLOAT_RESET = 1'b0;

	// arbiter states; gray along 0-1-3-2-6
	typedef enum logic [2:0] {
		ARB_IDLE = 3'h0,
		ARB_GRANT = 3'h1,
		ARB_HOLD = 3'h3,
		ARB_REVOKE = 3'h2,
		ARB_OWNED = 3'h6
	} arb_state_t;
endpackage

// ===== logic/sync_chain.sv
// multi-bit two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync_chain #(
	parameter int WIDTH = 2,
	parameter int STAGES = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [STAGES-1:0][WIDTH-1:0] stage_r;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.stage_r[0] = async_in;
		for (int i = 1; i < STAGES; i++) begin
			s_nxt.stage_r[i] = s_r.stage_r[i-1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// only the last stage is read outside
	assign sync_out = s_r.stage_r[STAGES-1];
endmodule

// ===== logic/bus_arbiter.sv
// three-wire bus arbiter: request, grant, grant acknowledge, bus float control
`timescale 1ns/1ps

module bus_arbiter
	import arb_pkg::*;
#(
	parameter int SYNC_DEPTH = arb_pkg::SYNC_STAGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// arbitration pins (active high, positive logic)
	input wire logic bus_request_in,
	input wire logic grant_acknowledge,
	output logic grant_out,
	// processor bus state
	input wire logic cycle_strobe,
	input wire logic locked_cycle_indicator,
	input wire logic cycle_decided,
	input wire logic cycle_started,
	// bus float control to the bus controller
	output logic bus_float,
	output logic bus_drive_en,
	output logic cycle_inhibit,
	// observation
	output arb_pkg::arb_state_t arb_state
);
	import arb_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [ASYNC_INPUTS-1:0] sync_vec;
	logic req_s;
	logic ack_s;

	sync_chain #(
		.WIDTH(ASYNC_INPUTS),
		.STAGES(SYNC_DEPTH)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({grant_acknowledge, bus_request_in}),
		.sync_out(sync_vec)
	);

	assign req_s = sync_vec[SYNC_BIT_REQ];
	assign ack_s = sync_vec[SYNC_BIT_ACK];

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		arb_state_t state_r;
		logic pending_r;
		logic float_r;
	} arb_regs_t;

	arb_regs_t r_r;
	arb_regs_t r_nxt;
	logic grant_fall_r;

	function automatic logic state_grants(input arb_state_t st);
		return (st == ARB_GRANT) || (st == ARB_HOLD);
	endfunction

	function automatic logic state_floats(input arb_state_t st);
		return st != ARB_IDLE;
	endfunction

	logic req_eff;
	logic grant_blocked;

	// in ARB_IDLE, lock masks the request and a decided but unstarted cycle only delays grant
	assign req_eff = req_s && !locked_cycle_indicator;
	assign grant_blocked = r_r.pending_r && !cycle_started;

	always_comb begin
		r_nxt = r_r;
		// remember an internal decision until that cycle begins
		if (cycle_started) begin
			r_nxt.pending_r = 1'b0;
		end else if (cycle_decided) begin
			r_nxt.pending_r = 1'b1;
		end
		case (r_r.state_r)
			ARB_IDLE: begin
				if (req_eff && !grant_blocked && !cycle_decided) begin
					r_nxt.state_r = ARB_GRANT;
				end else if (ack_s) begin
					r_nxt.state_r = ARB_OWNED;
				end else begin
					r_nxt.state_r = ARB_IDLE;
				end
			end
			ARB_GRANT: begin
				r_nxt.state_r = ARB_HOLD;
			end
			ARB_HOLD: begin
				if (ack_s || !req_s) begin
					r_nxt.state_r = ARB_REVOKE;
				end else begin
					r_nxt.state_r = ARB_HOLD;
				end
			end
			ARB_REVOKE: begin
				r_nxt.state_r = ARB_OWNED;
			end
			ARB_OWNED: begin
				if (ack_s && req_s) begin
					r_nxt.state_r = ARB_GRANT;
				end else if (ack_s) begin
					r_nxt.state_r = ARB_OWNED;
				end else begin
					r_nxt.state_r = ARB_IDLE;
				end
			end
			default: begin
				r_nxt.state_r = ARB_IDLE;
			end
		endcase
		// float once no strobe and no lock; drop at once when arbiter is idle
		if (!state_floats(r_nxt.state_r)) begin
			r_nxt.float_r = 1'b0;
		end else if (!cycle_strobe && !locked_cycle_indicator) begin
			r_nxt.float_r = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r <= '{state_r: ARB_IDLE, pending_r: 1'b0, float_r: FLOAT_RESET};
		end else begin
			r_r <= r_nxt;
		end
	end

	// grant pin follows the state on the falling edge
	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			grant_fall_r <= GRANT_RESET;
		end else begin
			grant_fall_r <= state_grants(r_r.state_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign grant_out = grant_fall_r;
	assign bus_float = r_r.float_r;
	assign bus_drive_en = !r_r.float_r;
	// no new external cycle while any arbitration is under way
	assign cycle_inhibit = state_floats(r_r.state_r);
	assign arb_state = r_r.state_r;
endmodule

// ===== test/arb_checker.sv
// port assertions for the bus arbiter
`timescale 1ns/1ps
module arb_checker
	import arb_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic bus_request_in,
	input wire logic grant_acknowledge,
	input wire logic grant_out,
	input wire logic cycle_strobe,
	input wire logic locked_cycle_indicator,
	input wire logic bus_float,
	input wire logic cycle_inhibit,
	input wire arb_state_t arb_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_inhibit_state: assert property (cycle_inhibit == (arb_state != ARB_IDLE))
		else $error("bad inhibit");
	chk_grant_pin: assert property (grant_out == (arb_state inside {ARB_GRANT, ARB_HOLD}))
		else $error("bad grant");
	chk_grant_hold: assert property (arb_state == ARB_GRANT |=> arb_state == ARB_HOLD)
		else $error("bad hold");
	chk_revoke_owned: assert property (arb_state == ARB_REVOKE |=> arb_state == ARB_OWNED)
		else $error("bad owned");
	chk_lock_block: assert property (locked_cycle_indicator && arb_state == ARB_IDLE |=> arb_state != ARB_GRANT)
		else $error("grant in lock");
	chk_idle_float: assert property (arb_state == ARB_IDLE |-> !bus_float)
		else $error("float in idle");
	chk_float_cond: assert property ($rose(bus_float) |-> !$past(cycle_strobe) && !$past(locked_cycle_indicator))
		else $error("early float");
	chk_idle_stay: assert property ((!bus_request_in && !grant_acknowledge)[*4] ##0 arb_state == ARB_IDLE
		|=> arb_state == ARB_IDLE)
		else $error("left idle");
	cover property (arb_state == ARB_HOLD ##1 arb_state == ARB_REVOKE);
	cover property (arb_state == ARB_OWNED);
	cover property ($fell(bus_float));
endmodule
bind bus_arbiter arb_checker arb_checker_inst (.clk, .rst, .bus_request_in, .grant_acknowledge, .grant_out,
	.cycle_strobe, .locked_cycle_indicator, .bus_float, .cycle_inhibit, .arb_state);

// ===== test/dma_model.sv
// alternate bus master with the three-wire handshake
`timescale 1ns/1ps
module dma_model #(
	parameter int HOLD = 12
) (
	// clock, reset, bench control
	input wire logic clk,
	input wire logic rst,
	input wire logic want,
	// bus pins
	input wire logic grant_out,
	input wire logic cycle_strobe,
	output logic bus_request_in,
	output logic grant_acknowledge
);
	int left;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_request_in <= 1'h0;
			grant_acknowledge <= 1'h0;
			left <= 0;
		end else if (grant_acknowledge) begin
			grant_acknowledge <= left != 0;
			left <= left - 1;
		end else if (want && grant_out && !cycle_strobe) begin
			grant_acknowledge <= 1'h1;
			bus_request_in <= 1'h0;
			left <= HOLD;
		end else
			bus_request_in <= want;
	end
endmodule

// ===== test/three_wire_bus_arbiter_test.sv
// self-checking bench for the bus arbiter
`timescale 1ns/1ps
module three_wire_bus_arbiter_test;
	import arb_pkg::*;
	logic clk = 1'h0, rst = 1'h1, want = 1'h0, stb = 1'h0, lock = 1'h0, dec = 1'h0, sta = 1'h0;
	logic req, ack, grant, flt, den;
	arb_state_t st;
	int num_errors = 0, checks = 0, cyc = 0;
	always #2 clk = ~clk;
	bus_arbiter bus_arbiter_inst (.clk, .rst, .bus_request_in(req), .grant_acknowledge(ack), .grant_out(grant),
		.cycle_strobe(stb), .locked_cycle_indicator(lock), .cycle_decided(dec), .cycle_started(sta),
		.bus_float(flt), .bus_drive_en(den), .cycle_inhibit(), .arb_state(st));
	dma_model dma_model_inst (.clk, .rst, .want, .grant_out(grant), .cycle_strobe(stb), .bus_request_in(req),
		.grant_acknowledge(ack));
	task chk(string n, logic [2:0] got, logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, exp, got);
		end
	endtask
	task final_report;
		$display("mismatches %0d of %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task own_and_return;
		@(posedge clk iff ack);
		want <= 1'h0;
		chk("float", flt, 3'h1);
		chk("drive", den, 3'h0);
		repeat (6) @(posedge clk);
		chk("state", st, ARB_OWNED);
		@(posedge clk iff !ack);
		repeat (6) @(posedge clk);
		chk("state", st, ARB_IDLE);
		chk("float", flt, 3'h0);
		chk("drive", den, 3'h1);
	endtask
	task t_lock;
		lock <= 1'h1;
		want <= 1'h1;
		repeat (10) @(posedge clk);
		chk("grant", grant, 3'h0);
		chk("state", st, ARB_IDLE);
		// the master waits out the lock rather than aborting it
		lock <= 1'h1;
		lock <= 1'h0;
		own_and_return;
		$display("lock done");
	endtask
	task t_defer;
		dec <= 1'h1;
		stb <= 1'h1;
		want <= 1'h1;
		@(posedge clk);
		dec <= 1'h0;
		repeat (8) @(posedge clk);
		chk("grant", grant, 3'h0);
		sta <= 1'h1;
		@(posedge clk iff grant);
		sta <= 1'h0;
		want <= 1'h0;
		repeat (10) @(posedge clk);
		chk("state", st, ARB_IDLE);
		stb <= 1'h0;
		$display("defer done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		want <= 1'h1;
		own_and_return;
		t_lock;
		t_defer;
		final_report;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			final_report;
		end
	end
endmodule
